// >>> tfp_pkg.sv
// constants, register map and mode codes of the 16-bit fast/phase-correct pwm timer
`default_nettype none
package tfp_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMPA = 8'h04;
  localparam logic [7:0] OFS_CMPB = 8'h08;
  localparam logic [7:0] OFS_CAPT = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  // ==========================================================
  // control register field positions
  localparam int CTRL_WS_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_CS_LSB = 8;
  localparam int CTRL_DIRA_BIT = 11;
  localparam int CTRL_DIRB_BIT = 12;
  localparam int CTRL_PORTA_BIT = 13;
  localparam int CTRL_PORTB_BIT = 14;
  localparam int CTRL_WIDTH = 15;
  // flag register bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CAPT = 1;
  localparam int FLG_MATCHA = 2;
  localparam int FLG_MATCHB = 3;
  // ==========================================================
  // reset values
  localparam logic [14:0] CTRL_RST = 15'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  // ==========================================================
  // waveform_select codes
  localparam logic [3:0] WS_PC8 = 4'h1;
  localparam logic [3:0] WS_PC9 = 4'h2;
  localparam logic [3:0] WS_PC10 = 4'h3;
  localparam logic [3:0] WS_FP8 = 4'h5;
  localparam logic [3:0] WS_FP9 = 4'h6;
  localparam logic [3:0] WS_FP10 = 4'h7;
  localparam logic [3:0] WS_PC_CAPT = 4'hA;
  localparam logic [3:0] WS_PC_CMPA = 4'hB;
  localparam logic [3:0] WS_FP_CAPT = 4'hE;
  localparam logic [3:0] WS_FP_CMPA = 4'hF;
  // fixed period limits and counter extremes
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_FULL = 16'hFFFF;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  // ==========================================================
  // output_action_field codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV = 2'h3;
  // ==========================================================
  // prescaler select codes and divider masks (divide by mask+1)
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PRE_MASK_1 = 10'h000;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  // ==========================================================
  // ahb-lite codes
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> tfp_pwm_timer.sv
// 16-bit timer with fast and phase correct pwm, ahb-lite register slave
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module tfp_pwm_timer
  import tfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pinAOut,
  output logic pinAOeN,
  output logic pinBOut,
  output logic pinBOeN
);

  // ==========================================================
  // decoding helpers
  // pwm mode families
  function automatic logic isFast(input logic [3:0] ws);
    isFast = (ws == WS_FP8) || (ws == WS_FP9) || (ws == WS_FP10) || (ws == WS_FP_CAPT) || (ws == WS_FP_CMPA);
  endfunction

  function automatic logic isPhase(input logic [3:0] ws);
    isPhase = (ws == WS_PC8) || (ws == WS_PC9) || (ws == WS_PC10) || (ws == WS_PC_CAPT) || (ws == WS_PC_CMPA);
  endfunction

  // resolution mask of fixed-top modes, full width otherwise
  function automatic logic [15:0] fixedMask(input logic [3:0] ws);
    unique case (ws)
      WS_PC8, WS_FP8: fixedMask = TOP_8BIT;
      WS_PC9, WS_FP9: fixedMask = TOP_9BIT;
      WS_PC10, WS_FP10: fixedMask = TOP_10BIT;
      default: fixedMask = TOP_FULL;
    endcase
  endfunction

  // divider mask of a prescaler select, stop gives no tick at all
  function automatic logic [9:0] preMask(input logic [2:0] cs);
    unique case (cs)
      CS_DIV8: preMask = PRE_MASK_8;
      CS_DIV64: preMask = PRE_MASK_64;
      CS_DIV256: preMask = PRE_MASK_256;
      CS_DIV1024: preMask = PRE_MASK_1024;
      default: preMask = PRE_MASK_1;
    endcase
  endfunction

  // next wave level of one channel on a tick
  function automatic logic waveNext(
    input logic fast,
    input logic phase,
    input logic toggleOk,
    input logic [1:0] act,
    input logic cur,
    input logic atTop,
    input logic hit,
    input logic upEff
  );
    logic inv;
    inv = (act == ACT_INV);
    waveNext = cur;
    if (act == ACT_TOGGLE)
    begin
      if (toggleOk && hit)
        waveNext = ~cur;
    end
    else if (act != ACT_OFF)
    begin
      if (fast)
      begin
        // top wins over match so compare==top holds a steady level
        if (atTop)
          waveNext = ~inv;
        else if (hit)
          waveNext = inv;
      end
      else if (phase && hit)
        waveNext = upEff ? inv : ~inv;
    end
  endfunction

  // ==========================================================
  // state
  logic [14:0] ctrl_r;
  logic [15:0] cmpABuf_r;
  logic [15:0] cmpBBuf_r;
  logic [15:0] cmpA_r;
  logic [15:0] cmpB_r;
  logic [15:0] capt_r;
  logic [15:0] count_r;
  logic countUp_r;
  logic [3:0] flags_r;
  logic [9:0] pre_r;
  logic waveA_r;
  logic waveB_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic rdPend_r;
  logic [7:0] rdAddr_r;

  logic [3:0] ws;
  logic [1:0] actA;
  logic [1:0] actB;
  logic [2:0] cs;
  logic fast;
  logic phase;
  logic tick;
  logic [15:0] topVal;
  logic atTop;
  logic atFloor;
  logic hitA;
  logic hitB;
  logic upEff;
  logic loadCmp;
  logic [15:0] count_nxt;
  logic countUp_nxt;
  logic [3:0] flagSet;
  logic [3:0] flagClr;
  logic takeAddr;
  logic wrEn;
  logic [15:0] wdMasked;
  logic [31:0] rdVal;

  assign ws = ctrl_r[CTRL_WS_LSB +: 4];
  assign actA = ctrl_r[CTRL_ACTA_LSB +: 2];
  assign actB = ctrl_r[CTRL_ACTB_LSB +: 2];
  assign cs = ctrl_r[CTRL_CS_LSB +: 3];
  assign fast = isFast(ws);
  assign phase = isPhase(ws);

  // ==========================================================
  // prescaler
  // free-running divider; a tick is one clk wide whatever the divide ratio
  always_ff @(posedge clk)
  begin
    if (rst)
      pre_r <= 10'h000;
    else
      pre_r <= pre_r + 10'h001;
  end

  assign tick = (cs != CS_STOP) && ((pre_r & preMask(cs)) == preMask(cs));

  // ==========================================================
  // period limit and counter sequencing
  // select period limit of fast and phase modes
  always_comb
  begin
    unique case (ws)
      WS_PC_CAPT, WS_FP_CAPT: topVal = capt_r;
      WS_PC_CMPA, WS_FP_CMPA: topVal = cmpA_r;
      default: topVal = fixedMask(ws);
    endcase
  end

  // exact compare only, a missed top runs through the wrap
  assign atTop = (count_r == topVal);
  assign atFloor = (count_r == COUNT_FLOOR);
  assign hitA = (count_r == cmpA_r);
  assign hitB = (count_r == cmpB_r);
  // direction seen by the output: top is a falling point, floor a rising one
  assign upEff = atFloor || (countUp_r && !atTop);
  // buffers load when count equals top
  // phase load at top, rising slope keeps old values
  assign loadCmp = tick && (fast || phase) && atTop;

  // next count, direction and flag events
  always_comb
  begin
    count_nxt = count_r;
    countUp_nxt = countUp_r;
    flagSet = 4'h0;
    if (fast)
    begin
      // clear on the tick after reaching top
      if (atTop)
      begin
        count_nxt = COUNT_FLOOR;
        flagSet[FLG_OVF] = 1'b1;
        flagSet[FLG_CAPT] = (ws == WS_FP_CAPT);
        flagSet[FLG_MATCHA] = (ws == WS_FP_CMPA);
      end
      else
        count_nxt = count_r + 16'h0001;
    end
    else if (phase)
    begin
      // up to top then down to floor
      if (countUp_r)
      begin
        if (atTop)
        begin
          // top held one tick, then decrement
          count_nxt = count_r - 16'h0001;
          countUp_nxt = 1'b0;
          flagSet[FLG_CAPT] = (ws == WS_PC_CAPT);
          flagSet[FLG_MATCHA] = (ws == WS_PC_CMPA);
        end
        else
          count_nxt = count_r + 16'h0001;
      end
      else if (atFloor)
      begin
        count_nxt = count_r + 16'h0001;
        countUp_nxt = 1'b1;
        flagSet[FLG_OVF] = 1'b1;
      end
      else
        count_nxt = count_r - 16'h0001;
    end
    if (fast || phase)
    begin
      flagSet[FLG_MATCHA] = flagSet[FLG_MATCHA] | hitA;
      flagSet[FLG_MATCHB] = flagSet[FLG_MATCHB] | hitB;
    end
  end

  // ==========================================================
  // ahb-lite slave
  // one wait state on reads so a read right after a write sees it
  assign takeAddr = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  assign wrEn = wrPend_r && hready;
  // fixed top masks high compare bits
  assign wdMasked = hwdata[15:0] & fixedMask(ws);
  assign flagClr = (wrEn && (wrAddr_r == OFS_FLAGS)) ? hwdata[3:0] : 4'h0;

  // address phase capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      rdPend_r <= 1'b0;
      rdAddr_r <= 8'h00;
    end
    else
    begin
      if (hready)
      begin
        wrPend_r <= takeAddr && hwrite;
        wrAddr_r <= haddr[7:0];
      end
      rdPend_r <= takeAddr && !hwrite;
      if (takeAddr && !hwrite)
        rdAddr_r <= haddr[7:0];
    end
  end

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rdVal = RDATA_ZERO;
    unique case (rdAddr_r)
      OFS_CTRL: rdVal = {17'h0_0000, ctrl_r};
      OFS_CMPA: rdVal = {16'h0000, cmpABuf_r};
      OFS_CMPB: rdVal = {16'h0000, cmpBBuf_r};
      OFS_CAPT: rdVal = {16'h0000, capt_r};
      OFS_COUNT: rdVal = {16'h0000, count_r};
      OFS_FLAGS: rdVal = {28'h000_0000, flags_r};
      default: rdVal = RDATA_ZERO;
    endcase
  end

  // ready and read data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hrdata <= RDATA_ZERO;
      hresp <= HRESP_OKAY;
    end
    else
    begin
      hresp <= HRESP_OKAY;
      if (takeAddr && !hwrite)
        hreadyout <= 1'b0;
      else if (rdPend_r)
      begin
        hreadyout <= 1'b1;
        hrdata <= rdVal;
      end
    end
  end

  // ==========================================================
  // software registers
  // control register
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_r <= CTRL_RST;
    else if (wrEn && (wrAddr_r == OFS_CTRL))
      ctrl_r <= hwdata[CTRL_WIDTH-1:0];
  end

  // capture value written straight, no buffer
  always_ff @(posedge clk)
  begin
    if (rst)
      capt_r <= VAL_RST;
    else if (wrEn && (wrAddr_r == OFS_CAPT))
      capt_r <= hwdata[15:0];
  end

  // compare buffers take every write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmpABuf_r <= VAL_RST;
      cmpBBuf_r <= VAL_RST;
    end
    else
    begin
      if (wrEn && (wrAddr_r == OFS_CMPA))
        cmpABuf_r <= wdMasked;
      if (wrEn && (wrAddr_r == OFS_CMPB))
        cmpBBuf_r <= wdMasked;
    end
  end

  // active compares follow buffers at top; outside pwm modes at once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmpA_r <= VAL_RST;
      cmpB_r <= VAL_RST;
    end
    else if (loadCmp || !(fast || phase))
    begin
      cmpA_r <= cmpABuf_r;
      cmpB_r <= cmpBBuf_r;
    end
  end

  // ==========================================================
  // counter
  // advances only on a tick; non-pwm modes hold
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_r <= VAL_RST;
      countUp_r <= 1'b1;
    end
    else if (wrEn && (wrAddr_r == OFS_COUNT))
      count_r <= hwdata[15:0];
    else if (tick)
    begin
      count_r <= count_nxt;
      countUp_r <= countUp_nxt;
    end
  end

  // flags set on ticks; a set beats a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (rst)
      flags_r <= FLAGS_RST;
    else
      flags_r <= (flags_r & ~flagClr) | (tick ? flagSet : 4'h0);
  end

  // ==========================================================
  // waveform generation
  // fast set at top, clear on match
  // spike at zero, steady level at top
  // toggle a only in mode 15
  // floor and top give steady levels
  // toggle a only in mode 11
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      waveA_r <= 1'b0;
      waveB_r <= 1'b0;
    end
    else if (tick)
    begin
      waveA_r <= waveNext(fast, phase, (ws == WS_FP_CMPA) || (ws == WS_PC_CMPA), actA, waveA_r, atTop, hitA, upEff);
      waveB_r <= waveNext(fast, phase, 1'b0, actB, waveB_r, atTop, hitB, upEff);
    end
  end

  // ==========================================================
  // pin multiplexing
  // a toggle code outside the toggle modes drives the held wave level, not the port bit
  // action zero keeps port function
  // drive only when direction is output
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinAOut <= 1'b0;
      pinAOeN <= 1'b1;
      pinBOut <= 1'b0;
      pinBOeN <= 1'b1;
    end
    else
    begin
      pinAOut <= (actA == ACT_OFF) ? ctrl_r[CTRL_PORTA_BIT] : waveA_r;
      pinBOut <= (actB == ACT_OFF) ? ctrl_r[CTRL_PORTB_BIT] : waveB_r;
      pinAOeN <= ~ctrl_r[CTRL_DIRA_BIT];
      pinBOeN <= ~ctrl_r[CTRL_DIRB_BIT];
    end
  end

endmodule // tfp_pwm_timer
`default_nettype wire

// >>> tfp_pwm_timer_asserts.sv
// bus and pin checker for the pwm timer, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module tfp_pwm_timer_asserts
  import tfp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic pinAOut,
  input wire logic pinAOeN,
  input wire logic pinBOut,
  input wire logic pinBOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // helpers
  logic aTake, rdTake, wrCtl_r;
  logic [31:0] ctl_r;
  logic [1:0] age_r;
  assign aTake = hsel && hready && htrans[1] && hsize == HSIZE_WORD;
  assign rdTake = aTake && !hwrite;
  // shadow of control; pins checked only once it has settled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrCtl_r <= 1'b0;
      ctl_r <= 32'h0000_0000;
      age_r <= 2'h3;
    end
    else
    begin
      wrCtl_r <= aTake && hwrite && haddr[7:0] == OFS_CTRL;
      if (wrCtl_r)
      begin
        ctl_r <= hwdata;
        age_r <= 2'h0;
      end
      else if (age_r != 2'h3)
        age_r <= age_r + 2'h1;
    end
  end
  // ==========================================
  // bus timing
  AST_HRESP_OKAY: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  AST_RD_WAIT: assert property (rdTake |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  AST_WR_NOWAIT: assert property (aTake && hwrite |=> hreadyout) else $error("write stalled");
  AST_WAIT_CAUSE: assert property ($fell(hreadyout) |-> $past(rdTake)) else $error("stray wait");
  AST_HRDATA_HOLD: assert property ($changed(hrdata) |-> $rose(hreadyout)) else $error("hrdata moved");
  AST_UNMAP_ZERO: assert property (rdTake && haddr[7:0] > OFS_FLAGS |-> ##2 hrdata == RDATA_ZERO)
    else $error("unmapped read not zero");
  // ==========================================
  // pin ownership
  // enable follows direction
  AST_OEN_A: assert property (age_r == 2'h3 |-> pinAOeN == !ctl_r[CTRL_DIRA_BIT]) else $error("oe a");
  AST_OEN_B: assert property (age_r == 2'h3 |-> pinBOeN == !ctl_r[CTRL_DIRB_BIT]) else $error("oe b");
  AST_PORT_A: assert property (age_r == 2'h3 && ctl_r[CTRL_ACTA_LSB +: 2] == ACT_OFF |->
    pinAOut == ctl_r[CTRL_PORTA_BIT]) else $error("port a");
  AST_PORT_B: assert property (age_r == 2'h3 && ctl_r[CTRL_ACTB_LSB +: 2] == ACT_OFF |->
    pinBOut == ctl_r[CTRL_PORTB_BIT]) else $error("port b");
  cover property (rdTake);
  cover property (age_r == 2'h3 && !pinAOeN && $rose(pinAOut));
  cover property (aTake && hwrite && haddr[7:0] == OFS_CMPA);
endmodule // tfp_pwm_timer_asserts
bind tfp_pwm_timer tfp_pwm_timer_asserts u_chk (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .pinAOut, .pinAOeN, .pinBOut, .pinBOeN);
`default_nettype wire

// >>> tfp_pin_load.sv
// external load on one waveform pin: resolves the level and tallies it
`timescale 1ns/10ps
`default_nettype none
module tfp_pin_load (
  input wire logic clk,
  input wire logic pinOut,
  input wire logic pinOeN,
  input wire logic clr,
  output logic pinLvl,
  output int highCnt,
  output int riseCnt
);
  logic flip_r = 1'b0;
  logic last_r = 1'b0;
  // wave seen only when driven
  // floating pin shows a changing pattern, never a held value
  assign pinLvl = pinOeN ? flip_r : pinOut;
  // tally high cycles and rising edges since the last clear
  always_ff @(posedge clk)
  begin
    flip_r <= !flip_r;
    last_r <= pinLvl;
    highCnt <= clr ? 0 : highCnt + int'(pinLvl);
    riseCnt <= clr ? 0 : riseCnt + int'(pinLvl && !last_r);
  end
endmodule // tfp_pin_load
`default_nettype wire

// >>> test_timer16_fast_and_phase_pwm.sv
// self-checking bench for the fast and phase correct pwm timer
`timescale 1ns/10ps
`default_nettype none
module test_timer16_fast_and_phase_pwm;
  import tfp_pkg::*;
  typedef struct {logic [3:0] ws; logic [1:0] act; logic [2:0] cs; logic [15:0] cmp; int win; int hi; int rise;} tfp_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic clr = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic hreadyout, hresp, pinAOut, pinAOeN, pinBOut, pinBOeN, lvlA;
  logic [31:0] hrdata, rd;
  int highCnt, riseCnt;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [3:0] fixWs [6] = '{WS_PC8, WS_PC9, WS_PC10, WS_FP8, WS_FP9, WS_FP10};
  logic [15:0] fixTop [6] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, TOP_8BIT, TOP_9BIT, TOP_10BIT};
  // mode, action, prescale, compare, window, high cycles, rises; top is capture 7, compare a, or 255 in the 8-bit rows
  tfp_row_t rows [14] = '{
    '{WS_FP_CAPT, ACT_NONINV, CS_DIV1, 16'h0002, 80, 30, 10},
    '{WS_FP_CAPT, ACT_INV, CS_DIV1, 16'h0002, 80, 50, 10},
    '{WS_FP_CAPT, ACT_NONINV, CS_DIV1, 16'h0000, 80, 10, 10},
    '{WS_FP_CAPT, ACT_NONINV, CS_DIV1, 16'h0007, 80, 80, 0},
    '{WS_FP_CAPT, ACT_NONINV, CS_DIV8, 16'h0002, 640, 240, 10},
    '{WS_FP8, ACT_NONINV, CS_DIV1, 16'h0040, 512, 130, 2},
    '{WS_FP_CMPA, ACT_TOGGLE, CS_DIV1, 16'h0003, 80, 40, 10},
    '{WS_PC_CAPT, ACT_NONINV, CS_DIV1, 16'h0002, 140, 40, 10},
    '{WS_PC_CAPT, ACT_INV, CS_DIV1, 16'h0002, 140, 100, 10},
    '{WS_PC_CAPT, ACT_NONINV, CS_DIV1, 16'h0000, 140, 0, 0},
    '{WS_PC_CAPT, ACT_NONINV, CS_DIV1, 16'h0007, 140, 140, 0},
    '{WS_PC8, ACT_NONINV, CS_DIV1, 16'h0040, 1020, 256, 2},
    '{WS_PC_CMPA, ACT_TOGGLE, CS_DIV1, 16'h0007, 140, 70, 5},
    '{WS_PC_CAPT, ACT_OFF, CS_DIV1, 16'h0002, 140, 140, 0}};
  // ==========================================
  // design, load and clock
  tfp_pwm_timer dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .pinAOut, .pinAOeN, .pinBOut, .pinBOeN);
  tfp_pin_load u_load (.clk, .pinOut(pinAOut), .pinOeN(pinAOeN), .clr, .pinLvl(lvlA), .highCnt, .riseCnt);
  always #12.5 clk = !clk;
  // ==========================================
  // tasks
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmp_cnt(input string nm, input int exp, input int got);
    total_checks++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // bounded wait for hready sampled high at an edge
  task automatic wait_hi;
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
      if (i > 40)
      begin
        n_mismatch++;
        print_verdict;
      end
    end
    while (hready_ok() == 1'b0);
  endtask
  function automatic logic hready_ok();
    return hreadyout === 1'b1;
  endfunction
  // one single word transfer; entered just after an edge
  task automatic bus(input logic isWr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= isWr;
    htrans <= 2'h2;
    wait_hi;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    cmp_word(nm, exp, rd);
  endtask
  // clear the load's tallies, then let exactly n samples count
  task automatic measure(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n + 1) @(posedge clk);
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] ws, input logic [1:0] act, input logic [2:0] cs, input logic dir);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[CTRL_WS_LSB +: 4] = ws;
    v[CTRL_ACTA_LSB +: 2] = act;
    v[CTRL_CS_LSB +: 3] = cs;
    v[CTRL_DIRA_BIT] = dir;
    v[CTRL_PORTA_BIT] = act == ACT_OFF;
    return v;
  endfunction
  // ==========================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(OFS_CTRL, 32'h0000_0000, "ctrl reset");
    rdchk(OFS_CMPA, 32'h0000_0000, "compare reset");
    rdchk(OFS_FLAGS, 32'h0000_0000, "flags reset");
    rdchk(8'h20, 32'h0000_0000, "unmapped read");
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CTRL, ctl(fixWs[i], ACT_OFF, CS_STOP, 1'b0));
      wr(OFS_CMPA, 32'h0000_FFFF);
      rdchk(OFS_CMPA, {16'h0000, fixTop[i]}, "masked compare");
    end
    // register top of 7: at least 3 and not below any compare used with it
    wr(OFS_CAPT, 32'h0000_0007);
    foreach (rows[i])
    begin
      // mode and top changed only with the prescaler stopped
      wr(OFS_CTRL, ctl(rows[i].ws, rows[i].act, CS_STOP, 1'b0));
      wr(OFS_COUNT, 32'h0000_0000);
      wr(OFS_FLAGS, 32'h0000_000F);
      wr(OFS_CMPA, {16'h0000, rows[i].cmp});
      cmp_word("pin released", 32'h0000_0001, {31'h0000_0000, pinAOeN});
      wr(OFS_CTRL, ctl(rows[i].ws, rows[i].act, rows[i].cs, 1'b1));
      repeat (rows[i].win) @(posedge clk);
      measure(rows[i].win);
      cmp_cnt("high cycles", rows[i].hi, highCnt);
      cmp_cnt("rising edges", rows[i].rise, riseCnt);
      rdchk(OFS_FLAGS, (rows[i].ws == WS_FP_CAPT || rows[i].ws == WS_PC_CAPT) ? 32'h0000_000F : 32'h0000_000D,
        "flags");
    end
    // counter placed above the capture top must run through the wrap first
    wr(OFS_CTRL, ctl(WS_FP_CAPT, ACT_NONINV, CS_STOP, 1'b1));
    wr(OFS_COUNT, 32'h0000_FFF0);
    wr(OFS_FLAGS, 32'h0000_000F);
    wr(OFS_CTRL, ctl(WS_FP_CAPT, ACT_NONINV, CS_DIV1, 1'b1));
    rdchk(OFS_FLAGS, 32'h0000_0000, "flags before wrap");
    repeat (40) @(posedge clk);
    rdchk(OFS_FLAGS, 32'h0000_000F, "flags after wrap");
    // channel b: driven as output with action off shows its port bit
    wr(OFS_CTRL, 32'h0000_5000);
    repeat (2) @(posedge clk);
    cmp_word("pin b port", 32'h0000_0001, {30'h0000_0000, pinBOeN, pinBOut});
    print_verdict;
  end
endmodule // test_timer16_fast_and_phase_pwm
`default_nettype wire
